// [sec_unlock_regs.svh]
// Register map, field positions, opcodes and reset values of the security unit.
// Assumes it is included by its bare name from the design file.
`ifndef SEC_UNLOCK_REGS_SVH
`define SEC_UNLOCK_REGS_SVH
`define SEC_A_CMD    8'h00
`define SEC_A_DATA   8'h04
`define SEC_A_STAT   8'h08
`define SEC_A_ISR    8'h0C
`define SEC_A_IMR    8'h10
`define SEC_A_REV    8'h14
`define SEC_A_CTRL   8'h18
`define SEC_OP_SETPW 8'hF1
`define SEC_OP_UNLK  8'hF2
`define SEC_OP_EPREP 8'hF3
`define SEC_OP_ERASE 8'hF4
`define SEC_OP_FRZ   8'hF5
`define SEC_B_ID     0
`define SEC_B_LVL    8
`define SEC_B_PWRON  0
`define SEC_B_HRST   1
`define SEC_W_FIRST  8'h00
`define SEC_W_PW0    8'h01
`define SEC_W_PW15   8'h10
`define SEC_W_REV    8'h11
`define SEC_W_LAST   8'hFF
`define SEC_TRIES    3'h5
`define SEC_REV_RST  16'h0000
`define SEC_RESP_OK  2'b00
`define SEC_RESP_ERR 2'b10
`endif

// [sec_pkg.sv]
// Types shared by the security command unit.
// Assumes nothing of its surroundings.
package sec_pkg;
    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_DATA = 2'b01,
        ST_EXEC = 2'b10
    } sec_state_t;
endpackage

// [sec_unlock.sv]
// Drive-side security command unit: set password, unlock, erase prepare.
// Assumes an AXI4-Lite master on aclk and a synchronous active-low reset.
//
// Chosen here: the AXI4-Lite register port and the register offsets.
`timescale 1ns/10ps
`include "sec_unlock_regs.svh"

// What this block does
// - Set password takes one data sector; its contents alone decide the effect.
// - Control bit 0 picks user or master; bit 8 picks High or Maximum.
// - Password comes from sector words 1 to 16, thirty-two bytes.
// - Word 17 is master revision code, used only when master is selected.
// - Revision code is reported as identify word 92; 0000h/FFFFh mean unsupported.
// - User password at High: store it, arm lock; user or master unlocks.
// - User password at Maximum: store it, arm lock; only user unlocks.
// - Master password: store it and revision; no arming, level kept.
// - Unlock takes one sector: bit 0 identifier, password in words 1-16.
// - Master unlock compares at High level, is rejected at Maximum.
// - User unlock compares user password; mismatch aborts and decrements counter.
// - Attempt counter starts at five, drops per unlock mismatch while locked.
// - At zero, unlock and erase unit abort until power-on or hard reset.
// - Unlock while already unlocked leaves the counter alone.
// - Erase unit aborts unless erase prepare completed immediately before.
// - While frozen, set password, unlock and erase commands are rejected.
module sec_unlock
    import sec_pkg::*;
(
    input  wire logic        aclk,    // Clock, 250 MHz.
    input  wire logic        aresetn, // Synchronous reset, active low.
    input  wire logic [7:0]  awaddr,  // Write address.
    input  wire logic        awvalid, // Write address valid.
    output wire logic        awready, // Write address ready.
    input  wire logic [31:0] wdata,   // Write data.
    input  wire logic [3:0]  wstrb,   // Write byte strobes.
    input  wire logic        wvalid,  // Write data valid.
    output wire logic        wready,  // Write data ready.
    output wire logic [1:0]  bresp,   // Write response.
    output wire logic        bvalid,  // Write response valid.
    input  wire logic        bready,  // Write response ready.
    input  wire logic [7:0]  araddr,  // Read address.
    input  wire logic        arvalid, // Read address valid.
    output wire logic        arready, // Read address ready.
    output wire logic [31:0] rdata,   // Read data.
    output wire logic [1:0]  rresp,   // Read response.
    output wire logic        rvalid,  // Read data valid.
    input  wire logic        rready,  // Read data ready.
    output wire logic        irq      // Interrupt, high while an unmasked event is pending.
);
    // Tells whether an address maps to a register.
    function automatic logic hit(input logic [7:0] a);
        return a == `SEC_A_CMD || a == `SEC_A_DATA || a == `SEC_A_STAT || a == `SEC_A_ISR
            || a == `SEC_A_IMR || a == `SEC_A_REV || a == `SEC_A_CTRL;
    endfunction
    // Tells whether an opcode touches the lock state.
    function automatic logic lock_op(input logic [7:0] op);
        return op == `SEC_OP_SETPW || op == `SEC_OP_UNLK || op == `SEC_OP_EPREP || op == `SEC_OP_ERASE;
    endfunction

    logic        aw_hold_reg, w_hold_reg, bvalid_reg, rvalid_reg;
    logic [7:0]  awa_reg;
    logic [31:0] wd_reg, rdata_reg;
    logic [3:0]  ws_reg;
    logic [1:0]  bresp_reg, rresp_reg;
    sec_state_t  st_reg;
    logic [7:0]  op_reg, widx_reg;
    logic        id_reg, lvl_in_reg, mis_reg;
    logic        locked_reg, armed_reg, lvl_reg, frozen_reg, prev_f3_reg, last_abt_reg;
    logic [2:0]  cnt_reg;
    logic [15:0] rev_reg;
    logic [1:0]  isr_reg, imr_reg;
    logic [15:0] usr_pw [16];
    logic [15:0] mst_pw [16];
    // Assertions share this clock and stay quiet while reset is held.
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);
    // Bus handshakes; the write fires once address and data are both held.
    assign awready = !aw_hold_reg && !bvalid_reg;
    assign wready  = !w_hold_reg && !bvalid_reg;
    assign arready = !rvalid_reg;
    assign bvalid  = bvalid_reg;
    assign bresp   = bresp_reg;
    assign rvalid  = rvalid_reg;
    assign rdata   = rdata_reg;
    assign rresp   = rresp_reg;
    wire wr_fire = aw_hold_reg && w_hold_reg && !bvalid_reg;
    wire wr_en   = wr_fire && hit(awa_reg) && ws_reg[1:0] == 2'b11;
    wire wr_cmd  = wr_en && awa_reg == `SEC_A_CMD;
    wire wr_dat  = wr_en && awa_reg == `SEC_A_DATA && st_reg == ST_DATA;
    wire wr_isr  = wr_en && awa_reg == `SEC_A_ISR;
    wire wr_imr  = wr_en && awa_reg == `SEC_A_IMR;
    wire wr_ctrl = wr_en && awa_reg == `SEC_A_CTRL;
    wire [15:0] dw = wd_reg[15:0];
    wire [7:0]  opw = wd_reg[7:0];
    // Command start and the verdicts that need no data sector.
    wire go      = wr_cmd && st_reg == ST_IDLE;
    wire is_ulk  = opw == `SEC_OP_UNLK;
    wire is_ers  = opw == `SEC_OP_ERASE;
    wire frz_blk = lock_op(opw) && frozen_reg;
    wire cnt_blk = (is_ulk || is_ers) && cnt_reg == 3'h0;
    wire prp_blk = is_ers && !prev_f3_reg;
    wire imm_abt = frz_blk || cnt_blk || prp_blk || !(lock_op(opw) || opw == `SEC_OP_FRZ);
    wire imm_fin = go && (imm_abt || opw == `SEC_OP_EPREP || opw == `SEC_OP_FRZ);
    wire to_data = go && !imm_fin;
    // Sector word decode and the stored word it is compared against.
    wire        in_pw = widx_reg >= `SEC_W_PW0 && widx_reg <= `SEC_W_PW15;
    wire [7:0]  wm1   = widx_reg - 8'h01;
    wire [3:0]  pidx  = wm1[3:0];
    wire [15:0] ref_w = id_reg ? mst_pw[pidx] : usr_pw[pidx];
    wire        pw_wr = wr_dat && op_reg == `SEC_OP_SETPW && in_pw;
    // Verdict at the end of a data sector.
    wire ex     = st_reg == ST_EXEC;
    wire m_max  = id_reg && lvl_reg;
    wire ex_abt = (op_reg == `SEC_OP_UNLK && (m_max || mis_reg)) || (op_reg == `SEC_OP_ERASE && mis_reg);
    wire fin    = imm_fin || ex;
    wire abt    = imm_fin ? imm_abt : (ex && ex_abt);
    wire [7:0] cur_op = imm_fin ? opw : op_reg;
    wire dec    = ex && op_reg == `SEC_OP_UNLK && !m_max && mis_reg && locked_reg && cnt_reg != 3'h0;
    wire [1:0] isr_clr = wr_isr ? wd_reg[1:0] : 2'b00;
    assign irq = |(isr_reg & imr_reg);
    // Status word as software reads it.
    wire [31:0] stat_w = {21'h0, cnt_reg, 1'b0, prev_f3_reg, last_abt_reg, frozen_reg,
                          lvl_reg, armed_reg, locked_reg, st_reg != ST_IDLE};
    wire [31:0] rd_mux = araddr == `SEC_A_CMD  ? {24'h0, op_reg} :
                         araddr == `SEC_A_STAT ? stat_w :
                         araddr == `SEC_A_ISR  ? {30'h0, isr_reg} :
                         araddr == `SEC_A_IMR  ? {30'h0, imr_reg} :
                         araddr == `SEC_A_REV  ? {16'h0, rev_reg} : 32'h0;

    // Write address and data capture and the write response.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_hold_reg <= 1'b0;
            w_hold_reg  <= 1'b0;
            bvalid_reg  <= 1'b0;
            bresp_reg   <= `SEC_RESP_OK;
            awa_reg     <= 8'h00;
            wd_reg      <= 32'h0;
            ws_reg      <= 4'h0;
        end else begin
            if (awvalid && awready) begin
                aw_hold_reg <= 1'b1;
                awa_reg     <= awaddr;
            end
            if (wvalid && wready) begin
                w_hold_reg <= 1'b1;
                wd_reg     <= wdata;
                ws_reg     <= wstrb;
            end
            if (wr_fire) begin
                aw_hold_reg <= 1'b0;
                w_hold_reg  <= 1'b0;
                bvalid_reg  <= 1'b1;
                bresp_reg   <= hit(awa_reg) ? `SEC_RESP_OK : `SEC_RESP_ERR;
            end else if (bvalid_reg && bready) begin
                bvalid_reg <= 1'b0;
            end
        end
    end

    // Read channel; the answer comes one cycle after the address is taken.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rvalid_reg <= 1'b0;
            rdata_reg  <= 32'h0;
            rresp_reg  <= `SEC_RESP_OK;
        end else if (arvalid && arready) begin
            rvalid_reg <= 1'b1;
            rdata_reg  <= rd_mux;
            rresp_reg  <= hit(araddr) ? `SEC_RESP_OK : `SEC_RESP_ERR;
        end else if (rvalid_reg && rready) begin
            rvalid_reg <= 1'b0;
        end
    end

    // Command sequencer: waits for the sector, checks passwords word by word.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            st_reg     <= ST_IDLE;
            op_reg     <= 8'h00;
            widx_reg   <= 8'h00;
            id_reg     <= 1'b0;
            lvl_in_reg <= 1'b0;
            mis_reg    <= 1'b0;
        end else begin
            unique case (st_reg)
                ST_IDLE: begin
                    if (go) begin
                        op_reg   <= opw;
                        widx_reg <= 8'h00;
                        mis_reg  <= 1'b0;
                    end
                    if (to_data) begin
                        st_reg <= ST_DATA;
                    end
                end
                ST_DATA: begin
                    if (wr_dat) begin
                        widx_reg <= widx_reg + 8'h01;
                        if (widx_reg == `SEC_W_FIRST) begin
                            id_reg     <= dw[`SEC_B_ID];
                            lvl_in_reg <= dw[`SEC_B_LVL];
                        end
                        if (in_pw && dw != ref_w) begin
                            mis_reg <= 1'b1;
                        end
                        if (widx_reg == `SEC_W_LAST) begin
                            st_reg <= ST_EXEC;
                        end
                    end
                end
                ST_EXEC: st_reg <= ST_IDLE;
                default: st_reg <= ST_IDLE;
            endcase
        end
    end

    // Password storage and revision code, written straight from the sector.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rev_reg <= `SEC_REV_RST;
            for (int i = 0; i < 16; i++) begin
                usr_pw[i] <= 16'h0000;
                mst_pw[i] <= 16'h0000;
            end
        end else begin
            if (pw_wr && id_reg) begin
                mst_pw[pidx] <= dw;
            end
            if (pw_wr && !id_reg) begin
                usr_pw[pidx] <= dw;
            end
            if (wr_dat && op_reg == `SEC_OP_SETPW && id_reg && widx_reg == `SEC_W_REV) begin
                rev_reg <= dw;
            end
        end
    end

    // Lock state, level, freeze, attempt counter and command history.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            locked_reg   <= 1'b0;
            armed_reg    <= 1'b0;
            lvl_reg      <= 1'b0;
            frozen_reg   <= 1'b0;
            prev_f3_reg  <= 1'b0;
            last_abt_reg <= 1'b0;
            cnt_reg      <= `SEC_TRIES;
        end else begin
            if (fin) begin
                prev_f3_reg  <= cur_op == `SEC_OP_EPREP && !abt;
                last_abt_reg <= abt;
            end
            if (imm_fin && opw == `SEC_OP_FRZ) begin
                frozen_reg <= 1'b1;
            end
            if (ex && !ex_abt && op_reg == `SEC_OP_SETPW && !id_reg) begin
                armed_reg <= 1'b1;
                lvl_reg   <= lvl_in_reg;
            end
            if (ex && !ex_abt && op_reg == `SEC_OP_UNLK) begin
                locked_reg <= 1'b0;
            end
            if (ex && !ex_abt && op_reg == `SEC_OP_ERASE) begin
                locked_reg <= 1'b0;
                armed_reg  <= 1'b0;
            end
            if (dec) begin
                cnt_reg <= cnt_reg - 3'h1;
            end
            if (wr_ctrl && (dw[`SEC_B_HRST] || dw[`SEC_B_PWRON])) begin
                cnt_reg     <= `SEC_TRIES;
                frozen_reg  <= 1'b0;
                prev_f3_reg <= 1'b0;
            end
            if (wr_ctrl && dw[`SEC_B_PWRON]) begin
                locked_reg <= armed_reg;
            end
        end
    end

    // Sticky events: set wins over a write-one clear in the same cycle.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            isr_reg <= 2'b00;
            imr_reg <= 2'b00;
        end else begin
            isr_reg <= (isr_reg & ~isr_clr) | {fin && abt, fin};
            if (wr_imr) begin
                imr_reg <= wd_reg[1:0];
            end
        end
    end

    // Checks on the command behaviour.
    property p_cnt_max;
        cnt_reg <= `SEC_TRIES;
    endproperty
    a_cnt_max: assert property (p_cnt_max) else $error("Attempt counter above start.");
    property p_cnt_step;
        !$stable(cnt_reg) && !$past(wr_ctrl) |-> cnt_reg == $past(cnt_reg) - 3'h1;
    endproperty
    a_cnt_step: assert property (p_cnt_step) else $error("Counter moved by other than one.");
    property p_cnt_hold;
        ex && op_reg == `SEC_OP_UNLK && !locked_reg |=> $stable(cnt_reg);
    endproperty
    a_cnt_hold: assert property (p_cnt_hold) else $error("Unlocked unlock changed counter.");
    property p_frz;
        go && frz_blk |=> isr_reg[1] && st_reg == ST_IDLE;
    endproperty
    a_frz: assert property (p_frz) else $error("Frozen command not rejected.");
    property p_zero;
        go && !frozen_reg && cnt_reg == 3'h0 && is_ulk |=> last_abt_reg ##1 st_reg == ST_IDLE;
    endproperty
    a_zero: assert property (p_zero) else $error("Unlock ran with counter at zero.");
    property p_prep;
        go && is_ers && !prev_f3_reg |=> last_abt_reg && !prev_f3_reg && $stable(locked_reg);
    endproperty
    a_prep: assert property (p_prep) else $error("Erase ran without prepare.");
    property p_mset;
        ex && op_reg == `SEC_OP_SETPW && id_reg |=> $stable(lvl_reg) && $stable(armed_reg) && !last_abt_reg;
    endproperty
    a_mset: assert property (p_mset) else $error("Master set changed level or arming.");
    property p_uset;
        ex && op_reg == `SEC_OP_SETPW && !id_reg |=> armed_reg && lvl_reg == $past(lvl_in_reg);
    endproperty
    a_uset: assert property (p_uset) else $error("User set did not arm.");
    property p_mmax;
        ex && op_reg == `SEC_OP_UNLK && id_reg && lvl_reg |=> last_abt_reg && $stable(locked_reg) && $stable(cnt_reg);
    endproperty
    a_mmax: assert property (p_mmax) else $error("Master unlock at Maximum not rejected.");
    c_unlock: cover property (ex && op_reg == `SEC_OP_UNLK && !ex_abt && locked_reg);
    c_cnt0:   cover property (dec && cnt_reg == 3'h1);
    c_erase:  cover property (ex && op_reg == `SEC_OP_ERASE && !ex_abt);
    c_frz:    cover property (go && frz_blk);

endmodule // sec_unlock

// [sec_host_model.sv]
// Host model: an AXI4-Lite master that issues security commands and their sectors.
// Assumes one clock shared with the unit; the bench calls its tasks after reset.
`timescale 1ns/10ps
`include "sec_unlock_regs.svh"
module sec_host_model (
    input  wire logic        aclk,    // Clock.
    output logic      [7:0]  awaddr,  // Write address.
    output logic             awvalid, // Address valid.
    input  wire logic        awready, // Address ready.
    output logic      [31:0] wdata,   // Write data.
    output logic      [3:0]  wstrb,   // Byte strobes.
    output logic             wvalid,  // Data valid.
    input  wire logic        wready,  // Data ready.
    input  wire logic [1:0]  bresp,   // Write response.
    input  wire logic        bvalid,  // Response valid.
    output logic             bready,  // Response ready.
    output logic      [7:0]  araddr,  // Read address.
    output logic             arvalid, // Read valid.
    input  wire logic        arready, // Read ready.
    input  wire logic [31:0] rdata,   // Read data.
    input  wire logic [1:0]  rresp,   // Read response.
    input  wire logic        rvalid,  // Read data valid.
    output logic             rready   // Read data ready.
);
    int lag = 0; // Cycles waited before taking a write response.
    logic [3:0] strb = 4'hF; // Byte strobes of the next writes.

    // Every request line starts idle.
    initial begin
        {awaddr, awvalid, wdata, wstrb, wvalid, bready} = '0;
        {araddr, arvalid, rready} = '0;
    end

    // One write; handshakes are judged mid-cycle, where the readies are settled.
    task automatic write_reg(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
        logic ah, wh, bh;
        int   n;
        @(posedge aclk);
        awaddr  <= a;
        wdata   <= d;
        wstrb   <= strb;
        awvalid <= 1'b1;
        wvalid  <= 1'b1;
        n = 0;
        bh = 1'b0;
        while (!bh) begin
            @(negedge aclk);
            ah = awvalid && awready;
            wh = wvalid && wready;
            bh = bvalid && bready;
            r = bresp;
            @(posedge aclk);
            n++;
            if (ah) awvalid <= 1'b0;
            if (wh) wvalid <= 1'b0;
            if (bh) bready <= 1'b0;
            else if (n >= lag) bready <= 1'b1;
        end
    endtask

    // One read; data and response are taken at the edge where rvalid is seen.
    task automatic read_reg(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
        logic ah, rh;
        @(posedge aclk);
        araddr  <= a;
        arvalid <= 1'b1;
        rready  <= 1'b1;
        rh = 1'b0;
        while (!rh) begin
            @(negedge aclk);
            ah = arvalid && arready;
            rh = rvalid && rready;
            d = rdata;
            r = rresp;
            @(posedge aclk);
            if (ah) arvalid <= 1'b0;
            if (rh) rready <= 1'b0;
        end
    endtask

    // Issues a command and, where asked, the full 256-word sector after it.
    task automatic send_cmd(input logic [7:0] op, input logic [15:0] ctrl, input logic [7:0] seed,
                            input logic [15:0] rev, input logic with_data);
        logic [1:0]  r;
        logic [15:0] w;
        write_reg(`SEC_A_CMD, {24'h0, op}, r);
        for (int i = 0; i < 256 && with_data; i++) begin
            w = (i == 0) ? ctrl : (i <= 16) ? {seed, 8'(i)} : (i == 17) ? rev : 16'hFFFF;
            write_reg(`SEC_A_DATA, {16'h0000, w}, r);
        end
    endtask
endmodule // sec_host_model

// [test_ata_security_password_unlock.sv]
// Testbench of the security command unit: host model, unit and command sequences.
// Assumes the unit's register header and the host model with its bus tasks.
`timescale 1ns/10ps
`include "sec_unlock_regs.svh"
module test_ata_security_password_unlock;
    logic        aclk;
    logic        aresetn;
    logic [7:0]  awaddr, araddr;
    logic [31:0] wdata, rdata, stat, val;
    logic [3:0]  wstrb;
    logic [1:0]  bresp, rresp, resp;
    logic        awvalid, awready, wvalid, wready, bvalid, bready;
    logic        arvalid, arready, rvalid, rready, irq;
    int          bad_count;
    int          compares;

    // The host model masters the bus and the unit answers it.
    sec_host_model u_host (.aclk(aclk), .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
        .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bresp(bresp),
        .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid), .arready(arready),
        .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready));
    sec_unlock u_dut (.aclk(aclk), .aresetn(aresetn), .awaddr(awaddr), .awvalid(awvalid),
        .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready),
        .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid),
        .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
        .irq(irq));

    // Clock of 4 ns.
    always #2 aclk = ~aclk;

    // Compares one value and reports a difference at once.
    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
        compares++;
        if (got !== exp) begin
            bad_count++;
            $display("MISMATCH at %0t: %s got %h expected %h", $time, what, got, exp);
        end
    endtask

    // Runs one command to its end, then checks the abort flag and the attempt counter.
    task automatic cmd(input logic [7:0] op, input logic [15:0] ctrl, input logic [7:0] seed,
                       input logic dat, input logic ab, input logic [2:0] cnt);
        u_host.send_cmd(op, ctrl, seed, {seed, 8'h5A}, dat);
        u_host.read_reg(`SEC_A_STAT, stat, resp);
        while (stat[0] === 1'b1) u_host.read_reg(`SEC_A_STAT, stat, resp);
        chk(32'(stat[5]), 32'(ab), "abort flag");
        chk(32'(stat[10:8]), 32'(cnt), "attempt counter");
    endtask

    // Prints the counts and the verdict, then ends the run.
    task automatic complete_run();
        $display("Compares %0d, mismatches %0d", compares, bad_count);
        if (bad_count == 0 && compares > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask

    // Cuts a hang short, well beyond the roughly 84 us that the sequence needs.
    initial begin
        #200000;
        bad_count++;
        $display("MISMATCH at %0t: watchdog expired", $time);
        complete_run();
    end

    // Main sequence of commands and checks.
    initial begin
        aclk = 1'b0;
        aresetn = 1'b0;
        bad_count = 0;
        compares = 0;
        repeat (5) @(posedge aclk);
        aresetn <= 1'b1;
        u_host.read_reg(`SEC_A_STAT, stat, resp);
        chk(stat & 32'h7FF, 32'h500, "status after reset");
        u_host.read_reg(`SEC_A_REV, val, resp);
        chk(val & 32'hFFFF, 32'h0, "revision after reset");
        u_host.write_reg(`SEC_A_IMR, 32'h3, resp);
        // Master password with every reserved bit and the level bit set.
        cmd(`SEC_OP_SETPW, 16'hFFFF, 8'hA0, 1'b1, 1'b0, 3'h5);
        chk(32'(stat[3:2]), 32'h0, "level and arming kept");
        u_host.read_reg(`SEC_A_REV, val, resp);
        chk(val & 32'hFFFF, 32'hA05A, "revision stored");
        chk(32'(irq), 32'h1, "interrupt on completion");
        u_host.write_reg(`SEC_A_ISR, 32'h3, resp);
        chk(32'(irq), 32'h0, "interrupt cleared");
        u_host.lag = 3;
        cmd(`SEC_OP_SETPW, 16'h00FE, 8'hB0, 1'b1, 1'b0, 3'h5);
        chk(32'(stat[3:2]), 32'h1, "user High armed");
        u_host.lag = 0;
        u_host.read_reg(`SEC_A_REV, val, resp);
        chk(val & 32'hFFFF, 32'hA05A, "revision kept on user set");
        u_host.write_reg(`SEC_A_CTRL, 32'h1, resp);
        cmd(`SEC_OP_UNLK, 16'h0001, 8'hA0, 1'b1, 1'b0, 3'h5);
        chk(32'(stat[1]), 32'h0, "master unlock at High");
        cmd(`SEC_OP_SETPW, 16'h0100, 8'hB0, 1'b1, 1'b0, 3'h5);
        chk(32'(stat[3]), 32'h1, "level Maximum");
        u_host.write_reg(`SEC_A_CTRL, 32'h1, resp);
        cmd(`SEC_OP_UNLK, 16'h0001, 8'hA0, 1'b1, 1'b1, 3'h5);
        for (int i = 0; i < 5; i++) begin
            cmd(`SEC_OP_UNLK, 16'hFFFE, 8'hC0 + 8'(i), 1'b1, 1'b1, 3'(4 - i));
        end
        cmd(`SEC_OP_UNLK, 16'h0000, 8'hB0, 1'b1, 1'b1, 3'h0);
        cmd(`SEC_OP_EPREP, 16'h0000, 8'hB0, 1'b0, 1'b0, 3'h0);
        cmd(`SEC_OP_ERASE, 16'h0000, 8'hB0, 1'b1, 1'b1, 3'h0);
        u_host.write_reg(`SEC_A_CTRL, 32'h2, resp);
        cmd(`SEC_OP_UNLK, 16'h0000, 8'hB0, 1'b1, 1'b0, 3'h5);
        chk(32'(stat[1]), 32'h0, "user unlock at Maximum");
        cmd(`SEC_OP_UNLK, 16'h0000, 8'hC7, 1'b1, 1'b1, 3'h5);
        cmd(`SEC_OP_ERASE, 16'h0000, 8'hB0, 1'b1, 1'b1, 3'h5);
        cmd(`SEC_OP_EPREP, 16'h0000, 8'hB0, 1'b0, 1'b0, 3'h5);
        chk(32'(stat[6]), 32'h1, "prepare recorded");
        cmd(`SEC_OP_ERASE, 16'h0000, 8'hB0, 1'b1, 1'b0, 3'h5);
        chk(32'(stat[2:1]), 32'h0, "erase unlocks and disarms");
        cmd(`SEC_OP_FRZ, 16'h0000, 8'hB0, 1'b0, 1'b0, 3'h5);
        chk(32'(stat[4]), 32'h1, "frozen");
        for (int k = 0; k < 4; k++) begin
            cmd(`SEC_OP_SETPW + 8'(k), 16'h0000, 8'hB0, 1'b1, 1'b1, 3'h5);
        end
        cmd(8'h77, 16'h0000, 8'hB0, 1'b0, 1'b1, 3'h5);
        u_host.read_reg(`SEC_A_CMD, val, resp);
        chk(val, 32'h77, "last opcode taken");
        u_host.write_reg(8'h40, 32'h1, resp);
        chk(32'(resp), 32'(`SEC_RESP_ERR), "unmapped write");
        u_host.read_reg(8'h40, val, resp);
        chk(32'(resp), 32'(`SEC_RESP_ERR), "unmapped read");
        u_host.strb = 4'hC;
        u_host.write_reg(`SEC_A_IMR, 32'h0, resp);
        u_host.strb = 4'hF;
        chk(32'(resp), 32'(`SEC_RESP_OK), "short strobe response");
        u_host.read_reg(`SEC_A_IMR, val, resp);
        chk(val, 32'h3, "short strobe write ignored");
        u_host.write_reg(`SEC_A_IMR, 32'h0, resp);
        chk(32'(irq), 32'h0, "interrupt masked");
        u_host.write_reg(`SEC_A_IMR, 32'h2, resp);
        chk(32'(irq), 32'h1, "abort interrupt unmasked");
        u_host.write_reg(`SEC_A_ISR, 32'h2, resp);
        chk(32'(irq), 32'h0, "abort event cleared");
        // A second reset in mid-run drops all security state, where a power-on keeps passwords, revision and level.
        @(posedge aclk);
        aresetn <= 1'b0;
        repeat (2) @(posedge aclk);
        aresetn <= 1'b1;
        u_host.read_reg(`SEC_A_STAT, stat, resp);
        chk(stat & 32'h7FF, 32'h500, "status after second reset");
        u_host.read_reg(`SEC_A_REV, val, resp);
        chk(val & 32'hFFFF, 32'h0, "revision after second reset");
        u_host.read_reg(`SEC_A_IMR, val, resp);
        chk(val, 32'h0, "mask after second reset");
        complete_run();
    end
endmodule // test_ata_security_password_unlock
